// ==== rtl/tmr_timer.sv ====
// Timer/counter with second compare, interrupt mask and flags, prescaler and external clock
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module tmr_timer
	import tmr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        external_count_pin,
	output logic             irq_compare_b,
	output logic             irq_compare_a,
	output logic             irq_overflow,
	output logic             compare_b_match
);
	typedef enum logic [1:0] {TMR_UP = 2'b00, TMR_DOWN = 2'b01} tmr_dir_t;

	function automatic logic [7:0] tmr_reg8(input logic [31:0] d, input logic [7:0] m);
		tmr_reg8 = d[7:0] & m;
	endfunction : tmr_reg8

	logic [7:0]  compare_b_value_q;
	logic [7:0]  compare_a_value_q;
	logic [7:0]  counter_value_q;
	logic [7:0]  counter_value_d;
	logic [3:1]  timer_interrupt_mask_q;
	logic [3:1]  timer_interrupt_flags_q;
	logic        sync_halt_mode_q;
	logic        prescaler_reset_bit_q;
	logic [2:0]  clock_select_field_q;
	logic [2:0]  waveform_mode_field_q;
	logic        global_irq_enable_q;
	logic [9:0]  presc_cnt_q;
	logic        pin_sync1_q;
	logic        pin_sync2_q;
	logic        pin_prev_q;
	logic        hreadyout_q;
	tmr_dir_t    dir_q;
	logic        wr_pend_q;
	logic        rd_pend_q;
	logic [7:0]  addr_q;
	logic [31:0] hrdata_q;
	logic        irq_b_q;
	logic        irq_a_q;
	logic        irq_ov_q;
	logic        match_b_q;

	// Bus decode
	wire         bus_go    = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	wire         wr_mask   = wr_pend_q & (addr_q == OFS_IRQ_MASK);
	wire         wr_flags  = wr_pend_q & (addr_q == OFS_IRQ_FLAGS);
	wire         wr_presc  = wr_pend_q & (addr_q == OFS_PRESC_CTRL);
	wire         wr_cmpb   = wr_pend_q & (addr_q == OFS_COMPARE_B);
	wire         wr_cmpa   = wr_pend_q & (addr_q == OFS_COMPARE_A);
	wire         wr_cnt    = wr_pend_q & (addr_q == OFS_COUNTER);
	wire         wr_ctrl   = wr_pend_q & (addr_q == OFS_TMR_CTRL);
	wire         wr_gie    = wr_pend_q & (addr_q == OFS_GLOBAL_IRQ);
	wire         wr_ack    = wr_pend_q & (addr_q == OFS_VECTOR_ACK);
	wire  [7:0]  wdat      = hwdata[7:0];
	wire  [7:0]  w_irq     = tmr_reg8(hwdata, IRQ_BITS_MASK);
	wire  [3:1]  flag_w1c  = wr_flags ? w_irq[3:1] : 3'h0;
	wire  [3:1]  vec_ack   = wr_ack ? w_irq[3:1] : 3'h0;

	// Prescaler taps; reset by the control bit, otherwise free running
	wire         presc_rst = prescaler_reset_bit_q;
	wire         tap8      = (presc_cnt_q[2:0] == 3'h7);
	wire         tap64     = (presc_cnt_q[5:0] == 6'h3f);
	wire         tap256    = (presc_cnt_q[7:0] == 8'hff);
	wire         tap1024   = (presc_cnt_q == PRESC_MAX);
	wire         ext_rise  = pin_sync2_q & ~pin_prev_q;
	wire         ext_fall  = ~pin_sync2_q & pin_prev_q;
	// Pulse is combinational so pin edge to counter update stays at three cycles
	wire         ext_pulse = ((clock_select_field_q == CS_EXT_RISE) & ext_rise) |
	                         ((clock_select_field_q == CS_EXT_FALL) & ext_fall);

	// Counter clock selection; external edges bypass the prescaler
	logic        cnt_tick;
	always_comb begin
		unique case (clock_select_field_q)
			CS_STOP:     cnt_tick = 1'b0;
			CS_DIV1:     cnt_tick = 1'b1;
			CS_DIV8:     cnt_tick = tap8 & ~presc_rst;
			CS_DIV64:    cnt_tick = tap64 & ~presc_rst;
			CS_DIV256:   cnt_tick = tap256 & ~presc_rst;
			CS_DIV1024:  cnt_tick = tap1024 & ~presc_rst;
			CS_EXT_FALL: cnt_tick = ext_pulse;
			CS_EXT_RISE: cnt_tick = ext_pulse;
		endcase
	end

	// Sync mode with the reset bit set halts every source, external edges too
	wire         tick      = cnt_tick & ~(sync_halt_mode_q & prescaler_reset_bit_q);
	wire         pc_mode   = (waveform_mode_field_q == WGM_PC_FF) ||
	                         (waveform_mode_field_q == WGM_PC_OCRA);
	wire         a_top     = (waveform_mode_field_q == WGM_CTC) ||
	                         (waveform_mode_field_q == WGM_PC_OCRA) ||
	                         (waveform_mode_field_q == WGM_FAST_OCRA);
	wire  [7:0]  top_val   = a_top ? compare_a_value_q : TOP_MAX;
	wire         at_top    = (counter_value_q == top_val);
	wire         hit_b     = tick & (counter_value_q == compare_b_value_q) & ~wr_cnt;
	wire         hit_a     = tick & (counter_value_q == compare_a_value_q) & ~wr_cnt;
	logic        ovf_hit;
	always_comb begin
		unique case (waveform_mode_field_q)
			WGM_PC_FF, WGM_PC_OCRA: ovf_hit = tick & (counter_value_q == BOTTOM) &
			                                  (dir_q == TMR_DOWN);
			WGM_FAST_OCRA:          ovf_hit = tick & at_top;
			default:                ovf_hit = tick & (counter_value_q == TOP_MAX);
		endcase
	end

	always_comb begin
		counter_value_d = counter_value_q;
		if (wr_cnt) begin
			counter_value_d = wdat;
		end else if (tick) begin
			if (pc_mode) begin
				if (dir_q == TMR_UP) begin
					counter_value_d = at_top ? counter_value_q - 8'h01 : counter_value_q + 8'h01;
				end else begin
					counter_value_d = (counter_value_q == BOTTOM) ? 8'h01 : counter_value_q - 8'h01;
				end
			end else if (at_top) begin
				counter_value_d = BOTTOM;
			end else begin
				counter_value_d = counter_value_q + 8'h01;
			end
		end
	end

	wire         dir_flip  = tick & pc_mode &
	                         ((dir_q == TMR_UP) ? at_top : (counter_value_q == BOTTOM));
	wire  [3:1]  flag_set  = {hit_b, hit_a, ovf_hit};
	// Set wins over a clear landing in the same cycle
	wire  [3:1]  flags_d   = flag_set | (timer_interrupt_flags_q & ~flag_w1c & ~vec_ack);
	wire  [3:1]  irq_live  = flags_d & timer_interrupt_mask_q & {3{global_irq_enable_q}};

	// Read mux
	logic [7:0]  rd_byte;
	always_comb begin
		unique case (addr_q)
			OFS_COMPARE_B:  rd_byte = compare_b_value_q;
			OFS_COMPARE_A:  rd_byte = compare_a_value_q;
			OFS_COUNTER:    rd_byte = counter_value_q;
			OFS_IRQ_MASK:   rd_byte = {4'h0, timer_interrupt_mask_q, 1'b0};
			OFS_IRQ_FLAGS:  rd_byte = {4'h0, timer_interrupt_flags_q, 1'b0};
			OFS_PRESC_CTRL: rd_byte = {sync_halt_mode_q, 6'h00, prescaler_reset_bit_q};
			OFS_TMR_CTRL:   rd_byte = {2'h0, waveform_mode_field_q, clock_select_field_q};
			OFS_GLOBAL_IRQ: rd_byte = {7'h00, global_irq_enable_q};
			default:        rd_byte = 8'h00;
		endcase
	end

	// Bus phase tracking; a read waits one cycle so its data comes from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q   <= 1'b0;
			rd_pend_q   <= 1'b0;
			addr_q      <= 8'h00;
			hreadyout_q <= 1'b1;
		end else begin
			wr_pend_q   <= bus_go & hwrite;
			rd_pend_q   <= bus_go & ~hwrite;
			hreadyout_q <= ~(bus_go & ~hwrite);
			if (bus_go) begin
				addr_q <= haddr;
			end
		end
	end

	// Read data is registered one cycle after the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0;
		end else if (bus_go & ~hwrite) begin
			hrdata_q <= 32'h0;
		end else if (rd_pend_q) begin
			hrdata_q <= {24'h0, rd_byte};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_b_value_q    <= 8'h00;
			compare_a_value_q    <= 8'h00;
			clock_select_field_q <= CS_STOP;
			waveform_mode_field_q <= WGM_NORMAL;
			global_irq_enable_q  <= 1'b0;
			timer_interrupt_mask_q <= 3'h0;
		end else begin
			if (wr_cmpb) begin
				compare_b_value_q <= wdat;
			end
			if (wr_cmpa) begin
				compare_a_value_q <= wdat;
			end
			if (wr_ctrl) begin
				clock_select_field_q  <= wdat[2:0];
				waveform_mode_field_q <= wdat[5:3];
			end
			if (wr_gie) begin
				global_irq_enable_q <= wdat[0];
			end
			if (wr_mask) begin
				timer_interrupt_mask_q <= w_irq[3:1];
			end
		end
	end

	// Prescaler control: reset bit held only under sync mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_halt_mode_q      <= 1'b0;
			prescaler_reset_bit_q <= 1'b0;
		end else if (wr_presc) begin
			sync_halt_mode_q      <= wdat[BIT_TSM];
			prescaler_reset_bit_q <= wdat[BIT_PSR];
		end else if (!sync_halt_mode_q) begin
			prescaler_reset_bit_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_cnt_q <= 10'h000;
		end else if (presc_rst) begin
			presc_cnt_q <= 10'h000;
		end else begin
			presc_cnt_q <= presc_cnt_q + 10'h001;
		end
	end

	// Two sampling flops then an edge flop; reset level matches the idle pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_sync1_q <= 1'b0;
			pin_sync2_q <= 1'b0;
			pin_prev_q  <= 1'b0;
		end else begin
			pin_sync1_q <= external_count_pin;
			pin_sync2_q <= pin_sync1_q;
			pin_prev_q  <= pin_sync2_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_value_q         <= 8'h00;
			dir_q                   <= TMR_UP;
			timer_interrupt_flags_q <= 3'h0;
		end else begin
			counter_value_q         <= counter_value_d;
			timer_interrupt_flags_q <= flags_d;
			if (dir_flip) begin
				dir_q <= (dir_q == TMR_UP) ? TMR_DOWN : TMR_UP;
			end
		end
	end

	// Interrupt requests registered so outputs come from flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_b_q   <= 1'b0;
			irq_a_q   <= 1'b0;
			irq_ov_q  <= 1'b0;
			match_b_q <= 1'b0;
		end else begin
			irq_b_q   <= irq_live[BIT_CMP_B];
			irq_a_q   <= irq_live[BIT_CMP_A];
			irq_ov_q  <= irq_live[BIT_OVF];
			match_b_q <= hit_b;
		end
	end

	assign hrdata          = hrdata_q;
	assign hreadyout       = hreadyout_q;
	assign hresp           = 1'b0;
	assign irq_compare_b   = irq_b_q;
	assign irq_compare_a   = irq_a_q;
	assign irq_overflow    = irq_ov_q;
	assign compare_b_match = match_b_q;

	property p_irq_b;
		@(posedge hclk) disable iff (!hresetn)
		irq_b_q |-> $past(timer_interrupt_mask_q[3]) && $past(global_irq_enable_q);
	endproperty
	a_irq_b: assert property (p_irq_b) else $error("compare b irq without enable");

	property p_irq_a;
		@(posedge hclk) disable iff (!hresetn)
		irq_a_q |-> $past(timer_interrupt_mask_q[2]) && $past(global_irq_enable_q);
	endproperty
	a_irq_a: assert property (p_irq_a) else $error("compare a irq without enable");

	property p_irq_ov;
		@(posedge hclk) disable iff (!hresetn)
		irq_ov_q |-> $past(timer_interrupt_flags_q[1] | ovf_hit) || timer_interrupt_flags_q[1];
	endproperty
	a_irq_ov: assert property (p_irq_ov) else $error("overflow irq without flag");

	property p_flag_b;
		@(posedge hclk) disable iff (!hresetn)
		hit_b |=> timer_interrupt_flags_q[3] && match_b_q;
	endproperty
	a_flag_b: assert property (p_flag_b) else $error("compare b flag not set");

	property p_flag_a;
		@(posedge hclk) disable iff (!hresetn)
		hit_a |=> timer_interrupt_flags_q[2];
	endproperty
	a_flag_a: assert property (p_flag_a) else $error("compare a flag not set");

	property p_ovf_normal;
		@(posedge hclk) disable iff (!hresetn)
		(tick && counter_value_q == TOP_MAX && waveform_mode_field_q == WGM_NORMAL && !wr_cnt)
		|=> timer_interrupt_flags_q[1] && counter_value_q == BOTTOM;
	endproperty
	a_ovf_normal: assert property (p_ovf_normal) else $error("normal overflow wrong");

	property p_w1c;
		@(posedge hclk) disable iff (!hresetn)
		(wr_flags && wdat[2] && !hit_a) |=> !timer_interrupt_flags_q[2];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

	property p_psr_self;
		@(posedge hclk) disable iff (!hresetn)
		(prescaler_reset_bit_q && !sync_halt_mode_q && !wr_presc) |=> !prescaler_reset_bit_q;
	endproperty
	a_psr_self: assert property (p_psr_self) else $error("reset bit not self cleared");

	property p_tsm_halt;
		@(posedge hclk) disable iff (!hresetn)
		(sync_halt_mode_q && prescaler_reset_bit_q && !wr_cnt) |=> $stable(counter_value_q);
	endproperty
	a_tsm_halt: assert property (p_tsm_halt) else $error("counter moved while halted");

	property p_ext_lat;
		@(posedge hclk) disable iff (!hresetn)
		(clock_select_field_q == CS_EXT_RISE && $rose(pin_sync1_q))
		|=> (ext_pulse || clock_select_field_q != CS_EXT_RISE);
	endproperty
	a_ext_lat: assert property (p_ext_lat) else $error("external edge not counted");

	property p_reserved;
		@(posedge hclk) disable iff (!hresetn)
		rd_pend_q && (addr_q == OFS_IRQ_FLAGS) |=> hrdata_q[7:4] == 4'h0 && !hrdata_q[0];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

	c_ovf:   cover property (@(posedge hclk) disable iff (!hresetn) ovf_hit);
	c_ext:   cover property (@(posedge hclk) disable iff (!hresetn) ext_pulse && tick);
	c_irq_b: cover property (@(posedge hclk) disable iff (!hresetn) irq_b_q);
	c_tsm:   cover property (@(posedge hclk) disable iff (!hresetn)
	                         sync_halt_mode_q ##1 !sync_halt_mode_q);
endmodule : tmr_timer

// ==== rtl/tmr_pkg.sv ====
// Package with register map, field positions and timing constants for the timer block
package tmr_pkg;
	localparam logic [7:0] OFS_COMPARE_B   = 8'h00;
	localparam logic [7:0] OFS_COMPARE_A   = 8'h04;
	localparam logic [7:0] OFS_COUNTER     = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h0c;
	localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h10;
	localparam logic [7:0] OFS_PRESC_CTRL  = 8'h14;
	localparam logic [7:0] OFS_TMR_CTRL    = 8'h18;
	localparam logic [7:0] OFS_GLOBAL_IRQ  = 8'h1c;
	localparam logic [7:0] OFS_VECTOR_ACK  = 8'h20;
	localparam int BIT_CMP_B   = 3;
	localparam int BIT_CMP_A   = 2;
	localparam int BIT_OVF     = 1;
	localparam int BIT_TSM     = 7;
	localparam int BIT_PSR     = 0;
	localparam logic [7:0] IRQ_BITS_MASK = 8'h0e;
	localparam logic [7:0] PRESC_BITS_MASK = 8'h81;
	localparam logic [7:0] TOP_MAX    = 8'hff;
	localparam logic [7:0] BOTTOM     = 8'h00;
	localparam logic [9:0] PRESC_MAX  = 10'h3ff;
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV64   = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam logic [2:0] WGM_NORMAL  = 3'h0;
	localparam logic [2:0] WGM_PC_FF   = 3'h1;
	localparam logic [2:0] WGM_CTC     = 3'h2;
	localparam logic [2:0] WGM_FAST_FF = 3'h3;
	localparam logic [2:0] WGM_PC_OCRA = 3'h5;
	localparam logic [2:0] WGM_FAST_OCRA = 3'h7;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage : tmr_pkg

// ==== test/tmr_ext_source.sv ====
// Model of the external clock source that drives the count pin
`timescale 1ns/1ns
module tmr_ext_source (
	input  wire logic hclk,
	output logic      pin
);
	initial pin = 1'b0;
	// Pin stands still between bursts, so clock select may change safely
	task automatic burst(input int n, input int half);
		for (int i = 0; i < 2 * n; i++) begin
			@(posedge hclk);
			pin <= ~pin;
			// Half period of three cycles keeps below the system clock over 2.5
			repeat (half - 1) @(posedge hclk);
		end
	endtask : burst
endmodule : tmr_ext_source

// ==== test/tmr_timer_tb_top.sv ====
// Self-checking testbench for the timer block
`timescale 1ns/1ns
module tmr_timer_tb_top
	import tmr_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        pin;
	logic        irq_b;
	logic        irq_a;
	logic        irq_o;
	logic        match_b;
	logic [31:0] lfsr_q = 32'h41ae7d1c;
	logic [31:0] rv;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          n_match = 0;
	int          mdl [0:8];
	int          divs [0:3] = '{8, 64, 256, 1024};

	tmr_timer i_tmr_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.external_count_pin(pin), .irq_compare_b(irq_b), .irq_compare_a(irq_a),
		.irq_overflow(irq_o), .compare_b_match(match_b));
	tmr_ext_source i_tmr_ext_source (.hclk(hclk), .pin(pin));

	always #5 hclk = ~hclk;

	always @(posedge hclk) begin
		if (match_b === 1'b1)
			n_match++;
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			$display("timeout after %0d cycles", cyc);
			end_sim();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Address phase, then data phase; read data is taken at the edge that ends it
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		case (a)
			OFS_IRQ_MASK: mdl[3] = d & 32'h0e;
			OFS_IRQ_FLAGS: mdl[4] = mdl[4] & ~d & 32'h0e;
			OFS_VECTOR_ACK: mdl[4] = mdl[4] & ~d & 32'h0e;
			OFS_PRESC_CTRL: mdl[5] = d[7] ? d & 32'h81 : 32'h0;
			default: if (a <= OFS_TMR_CTRL) mdl[a >> 2] = d & 32'hff;
		endcase
	endtask : wr

	task automatic rd(input logic [7:0] a, input string name);
		bus(1'b0, a, 32'h0);
		chk(name, (a <= OFS_VECTOR_ACK) ? mdl[a >> 2] : 0, rv);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : rd

	initial begin
		foreach (mdl[i])
			mdl[i] = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd(OFS_COMPARE_B, "compare_b_value");
		rd(OFS_IRQ_MASK, "timer_interrupt_mask");
		rd(OFS_IRQ_FLAGS, "timer_interrupt_flags");
		rd(OFS_PRESC_CTRL, "prescaler_sync_control");
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			lfsr_q = lfsr(lfsr_q);
			wr(OFS_COMPARE_B, lfsr_q);
			rd(OFS_COMPARE_B, "compare_b_value");
			wr(OFS_IRQ_MASK, lfsr_q ^ 32'hf1);
			rd(OFS_IRQ_MASK, "timer_interrupt_mask");
		end
		rd(8'h24, "unmapped");
		$display("test register access done");
		wr(OFS_COMPARE_B, 32'h10);
		wr(OFS_COMPARE_A, 32'h20);
		wr(OFS_COUNTER, 32'h0e);
		n_match = 0;
		wr(OFS_TMR_CTRL, {26'h0, WGM_NORMAL, CS_DIV1});
		repeat (60) @(posedge hclk);
		wr(OFS_TMR_CTRL, CS_STOP);
		mdl[4] = 32'h0c;
		rd(OFS_IRQ_FLAGS, "compare flags");
		chk("compare_b_match pulses", 1, n_match);
		wr(OFS_COUNTER, 32'hf8);
		wr(OFS_TMR_CTRL, {26'h0, WGM_NORMAL, CS_DIV1});
		repeat (10) @(posedge hclk);
		wr(OFS_TMR_CTRL, CS_STOP);
		mdl[4] = 32'h0e;
		rd(OFS_IRQ_FLAGS, "overflow flag");
		$display("test flags done");
		wr(OFS_GLOBAL_IRQ, 32'h1);
		for (int b = 1; b < 4; b++) begin
			wr(OFS_IRQ_MASK, 32'h1 << b);
			repeat (2) @(posedge hclk);
			chk("irq outputs", 32'h1 << b, {28'h0, irq_b, irq_a, irq_o, 1'b0});
		end
		wr(OFS_GLOBAL_IRQ, 32'h0);
		repeat (2) @(posedge hclk);
		chk("irq outputs gated", 0, {28'h0, irq_b, irq_a, irq_o, 1'b0});
		wr(OFS_IRQ_FLAGS, 32'hf4);
		rd(OFS_IRQ_FLAGS, "flags after write one");
		wr(OFS_VECTOR_ACK, 32'h08);
		rd(OFS_IRQ_FLAGS, "flags after vector");
		wr(OFS_IRQ_FLAGS, 32'h00);
		rd(OFS_IRQ_FLAGS, "flags after write zero");
		wr(OFS_IRQ_FLAGS, 32'h02);
		rd(OFS_IRQ_FLAGS, "flags cleared");
		$display("test interrupts done");
		wr(OFS_COUNTER, 32'h1e);
		wr(OFS_TMR_CTRL, {26'h0, WGM_CTC, CS_DIV1});
		repeat (10) @(posedge hclk);
		wr(OFS_TMR_CTRL, CS_STOP);
		mdl[2] = 32'h0a;
		rd(OFS_COUNTER, "clear on compare a");
		mdl[4] = 32'h04;
		rd(OFS_IRQ_FLAGS, "flags in clear mode");
		wr(OFS_IRQ_FLAGS, 32'h0e);
		$display("test clear on compare done");
		for (int e = 0; e < 2; e++) begin
			wr(OFS_COUNTER, 32'h0);
			wr(OFS_TMR_CTRL, e ? CS_EXT_FALL : CS_EXT_RISE);
			i_tmr_ext_source.burst(5 - e, 3);
			repeat (8) @(posedge hclk);
			wr(OFS_TMR_CTRL, CS_STOP);
			mdl[2] = 5 - e;
			rd(OFS_COUNTER, "external count");
		end
		$display("test external clock done");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_PRESC_CTRL, 32'h81);
			rd(OFS_PRESC_CTRL, "reset bit held");
			wr(OFS_COUNTER, 32'h0);
			wr(OFS_TMR_CTRL, CS_DIV8 + i[2:0]);
			repeat (40) @(posedge hclk);
			rd(OFS_COUNTER, "halted counter");
			wr(OFS_PRESC_CTRL, 32'h0);
			repeat (4 * divs[i]) @(posedge hclk);
			wr(OFS_TMR_CTRL, CS_STOP);
			bus(1'b0, OFS_COUNTER, 32'h0);
			// Prescaler restarts on release, so four periods give exactly four counts
			chk("prescaled count", 32'h4, rv);
			wr(OFS_PRESC_CTRL, 32'h01);
			rd(OFS_PRESC_CTRL, "reset bit cleared");
		end
		$display("test prescaler done");
		end_sim();
	end
endmodule : tmr_timer_tb_top
